// *** include/rlc_params.svh ***
// Constants for the redriver lane control block: offsets, fields, timing.
// Assumes inclusion by bare name from the design files.
`ifndef RLC_PARAMS_SVH
`define RLC_PARAMS_SVH

`define RLC_LANES 4
`define RLC_PIN_W 16
`define RLC_CLK_PERIOD_NS 8
// Spacing of detection attempts on a lane
`define RLC_ATTEMPT_NS 1000
`define RLC_ATTEMPT_CYCLES ((`RLC_ATTEMPT_NS + `RLC_CLK_PERIOD_NS - 1) / `RLC_CLK_PERIOD_NS)
`define RLC_RETRY_LIMIT 2'h3

`define RLC_ADDR_CTRL 8'h00
`define RLC_ADDR_STATUS 8'h04
`define RLC_ADDR_SETTING 8'h08
`define RLC_CTRL_START_BIT 0
`define RLC_CTRL_FORCE_PS_BIT 1
`define RLC_CTRL_RESET 1'h0

`define RLC_EQ_NONE 2'h0
`define RLC_EQ_3P5DB 2'h1
`define RLC_EQ_6DB 2'h2

`endif

// *** include/rlc_pkg.sv ***
// Types shared by the redriver lane control design.
// Assumes rlc_params.svh is on the include path.
`include "rlc_params.svh"

package rlc_pkg;

  typedef enum logic [1:0] {st_off, st_detect, st_run} rlc_state_e;
  typedef logic [1:0] rlc_level_t;

  // Two-bit strap code to level; upper bit wins
  function automatic rlc_level_t level_of(input logic msb, input logic lsb);
    if (msb) begin
      level_of = `RLC_EQ_6DB;
    end else if (lsb) begin
      level_of = `RLC_EQ_3P5DB;
    end else begin
      level_of = `RLC_EQ_NONE;
    end
  endfunction

endpackage

// *** verilog/rlc_sync.sv ***
// Two-stage synchroniser for pin-level inputs.
// Assumes levels that change slowly against i_clock.
`timescale 1ns/10ps
`default_nettype none
`include "rlc_params.svh"

module rlc_sync #(
  parameter int W = `RLC_PIN_W
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] stage1;

  // Reset to low, as pulled-down pads read when undriven
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

`default_nettype wire

// *** verilog/rlc_lane.sv ***
// One lane of receiver detection: found flag and bounded retry count.
// Assumes i_attempt is a one-cycle pulse and i_present is synchronised.
`timescale 1ns/10ps
`default_nettype none
`include "rlc_params.svh"

module rlc_lane (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clear,
  input wire logic i_active,
  input wire logic i_attempt,
  input wire logic i_any_found,
  input wire logic i_present,
  output logic o_found,
  output logic [1:0] o_retries,
  output logic o_done
);

  logic found;
  logic [1:0] retries;
  logic next_found;
  logic [1:0] next_retries;

  always_comb begin
    next_found = found;
    next_retries = retries;
    if (i_clear) begin
      next_found = 1'b0;
      next_retries = 2'h0;
    end else if (i_active && i_attempt && !found && retries != `RLC_RETRY_LIMIT) begin
      if (i_present) begin
        next_found = 1'b1;
      end else if (i_any_found) begin
        next_retries = retries + 2'h1;
      end
      // No lane found yet: retry count stays, attempts go on
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      found <= 1'b0;
      retries <= 2'h0;
    end else begin
      found <= next_found;
      retries <= next_retries;
    end
  end

  assign o_found = found;
  assign o_retries = retries;
  assign o_done = found || (retries == `RLC_RETRY_LIMIT);

endmodule

`default_nettype wire

// *** verilog/rlc_control.sv ***
// Redriver lane control: strap decode, detection sequencing, lane gating,
// and an AHB-Lite register slave.
// Assumes pins and analog lane results arrive asynchronously; one clock.
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "rlc_params.svh"

module rlc_control (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire logic i_detect_request,
  input wire logic i_swing_select,
  input wire logic i_power_save_in,
  input wire logic i_in_boost_msb,
  input wire logic i_in_boost_lsb,
  input wire logic i_out_deemph_msb,
  input wire logic i_out_deemph_lsb,
  input wire logic [3:0] i_rx_present,
  input wire logic [3:0] i_idle_above,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [1:0] o_in_boost,
  output logic [1:0] o_out_deemph,
  output logic o_swing_large,
  output logic o_standby,
  output logic [3:0] o_detect_request_en,
  output logic [3:0] o_detect_strobe,
  output logic [3:0] o_drive_en,
  output logic [3:0] o_idle_det_en,
  output logic [3:0] o_lane_out_on
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [`RLC_PIN_W-1:0] pin_raw;
  logic [`RLC_PIN_W-1:0] pin_s;
  logic en_s;
  logic req_s;
  logic swing_s;
  logic ps_pin_s;
  logic [3:0] present_s;
  logic [3:0] above_s;

  assign pin_raw = {i_idle_above, i_rx_present, i_in_boost_msb, i_in_boost_lsb,
                    i_out_deemph_msb, i_out_deemph_lsb, i_power_save_in,
                    i_swing_select, i_detect_request, i_enable};

  rlc_sync #(.W(`RLC_PIN_W)) u_sync (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async(pin_raw),
    .o_sync(pin_s)
  );

  assign en_s = pin_s[0];
  assign req_s = pin_s[1];
  assign swing_s = pin_s[2];
  assign ps_pin_s = pin_s[3];
  assign present_s = pin_s[11:8];
  assign above_s = pin_s[15:12];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state

  rlc_pkg::rlc_state_e state;
  rlc_pkg::rlc_state_e next_state;
  logic req_prev;
  logic next_req_prev;
  logic [7:0] timer;
  logic [7:0] next_timer;
  logic ctrl_force_ps;
  logic next_ctrl_force_ps;
  logic sw_start;
  logic next_sw_start;
  logic clear;
  logic attempt;
  logic start_req;
  logic ps_eff;
  logic [3:0] lane_active;
  logic [3:0] lane_found;
  logic [3:0] lane_done_raw;
  logic [3:0] lane_done;
  logic [7:0] lane_retries;
  logic [3:0] eff_found;
  logic [3:0] eff_above;

  // Power save from the pin, or forced by software
  assign ps_eff = ps_pin_s | ctrl_force_ps;
  // A rising edge of the request pin or a software start counts; a held level does nothing
  assign start_req = (req_s && !req_prev) || sw_start;
  assign attempt = (state == rlc_pkg::st_detect) &&
                   (timer == 8'(`RLC_ATTEMPT_CYCLES - 1));

  always_comb begin
    next_state = state;
    next_req_prev = req_s;
    clear = !en_s;
    case (state)
      rlc_pkg::st_off: begin
        // Enable rising, including power-up with enable high
        if (en_s) begin
          next_state = rlc_pkg::st_detect;
          clear = 1'b1;
        end
      end
      rlc_pkg::st_detect: begin
        if (!en_s) begin
          next_state = rlc_pkg::st_off;
        end else if (start_req) begin
          clear = 1'b1;
        end else if (&lane_done) begin
          next_state = rlc_pkg::st_run;
        end
      end
      rlc_pkg::st_run: begin
        if (!en_s) begin
          next_state = rlc_pkg::st_off;
        end else if (start_req) begin
          next_state = rlc_pkg::st_detect;
          clear = 1'b1;
        end
      end
      default: begin
        next_state = rlc_pkg::st_off;
      end
    endcase
    if (clear || state != rlc_pkg::st_detect || attempt) begin
      next_timer = 8'h00;
    end else begin
      next_timer = timer + 8'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state <= rlc_pkg::st_off;
      req_prev <= 1'b0;
      timer <= 8'h00;
    end else begin
      state <= next_state;
      req_prev <= next_req_prev;
      timer <= next_timer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lanes

  genvar g;
  generate
    for (g = 0; g < `RLC_LANES; g++) begin : g_lane
      // Lanes 1 to 3 sit idle in power save
      assign lane_active[g] = (g == 0) || !ps_eff;
      assign lane_done[g] = lane_done_raw[g] || !lane_active[g];
      rlc_lane u_lane (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_clear(clear),
        .i_active(lane_active[g] && state == rlc_pkg::st_detect),
        .i_attempt(attempt),
        .i_any_found(|(lane_found & lane_active)),
        .i_present(present_s[g]),
        .o_found(lane_found[g]),
        .o_retries(lane_retries[2*g+1:2*g]),
        .o_done(lane_done_raw[g])
      );
    end
  endgenerate

  // Power save: the found flag and idle level of every lane follow lane 0
  assign eff_found = ps_eff ? {4{lane_found[0]}} : lane_found;
  assign eff_above = ps_eff ? {4{above_s[0]}} : above_s;

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs

  logic [1:0] next_in_boost;
  logic [1:0] next_out_deemph;
  logic next_swing_large;
  logic next_standby;
  logic [3:0] next_detect_request_en;
  logic [3:0] next_detect_strobe;
  logic [3:0] next_drive_en;
  logic [3:0] next_idle_det_en;
  logic [3:0] next_lane_out_on;

  always_comb begin
    next_in_boost = rlc_pkg::level_of(pin_s[7], pin_s[6]);
    next_out_deemph = rlc_pkg::level_of(pin_s[5], pin_s[4]);
    next_swing_large = !swing_s;
    // Standby covers disable and the whole detection sequence
    next_standby = (state != rlc_pkg::st_run);
    next_detect_request_en = (state == rlc_pkg::st_detect) ? lane_active : 4'h0;
    next_detect_strobe = attempt ? (lane_active & ~lane_found) : 4'h0;
    next_drive_en = (state == rlc_pkg::st_run) ? eff_found : 4'h0;
    next_idle_det_en = next_drive_en & lane_active;
    next_lane_out_on = next_drive_en & eff_above;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_in_boost <= `RLC_EQ_NONE;
      o_out_deemph <= `RLC_EQ_NONE;
      o_swing_large <= 1'b1;
      o_standby <= 1'b1;
      o_detect_request_en <= 4'h0;
      o_detect_strobe <= 4'h0;
      o_drive_en <= 4'h0;
      o_idle_det_en <= 4'h0;
      o_lane_out_on <= 4'h0;
    end else begin
      o_in_boost <= next_in_boost;
      o_out_deemph <= next_out_deemph;
      o_swing_large <= next_swing_large;
      o_standby <= next_standby;
      o_detect_request_en <= next_detect_request_en;
      o_detect_strobe <= next_detect_strobe;
      o_drive_en <= next_drive_en;
      o_idle_det_en <= next_idle_det_en;
      o_lane_out_on <= next_lane_out_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states

  logic wr_pend;
  logic next_wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic take;

  assign take = i_hsel && i_htrans[1] && i_hready;

  always_comb begin
    next_wr_pend = take && i_hwrite;
    next_wr_addr = i_haddr[7:0];
    next_ctrl_force_ps = ctrl_force_ps;
    next_sw_start = 1'b0;
    if (wr_pend && wr_addr == `RLC_ADDR_CTRL) begin
      next_ctrl_force_ps = i_hwdata[`RLC_CTRL_FORCE_PS_BIT];
      // Start acts only while enabled, like the pin edge
      next_sw_start = i_hwdata[`RLC_CTRL_START_BIT] && en_s;
    end
    // Read data is prepared in the address phase so it leaves a flop
    next_hrdata = 32'h0000_0000;
    if (take && !i_hwrite) begin
      case (i_haddr[7:0])
        `RLC_ADDR_CTRL: next_hrdata = {30'h0, ctrl_force_ps, 1'b0};
        `RLC_ADDR_STATUS: next_hrdata = {16'h0, lane_retries, 1'b0, ps_eff,
                                         state == rlc_pkg::st_run,
                                         state == rlc_pkg::st_detect, lane_found};
        `RLC_ADDR_SETTING: next_hrdata = {26'h0, next_swing_large,
                                          o_out_deemph, o_in_boost, en_s};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      ctrl_force_ps <= `RLC_CTRL_RESET;
      sw_start <= 1'b0;
      o_hrdata <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      ctrl_force_ps <= next_ctrl_force_ps;
      sw_start <= next_sw_start;
      o_hrdata <= next_hrdata;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** bench/rlc_partner.sv ***
// Link partner model: receiver terminations on four lanes.
// Assumes the bench picks which lanes have a receiver attached.
`timescale 1ns/10ps
`default_nettype none

module rlc_partner (
  input wire logic i_clock,
  input wire logic i_clear,
  input wire logic [3:0] i_attached,
  input wire logic [3:0] i_det_en,
  input wire logic [3:0] i_strobe,
  output logic [3:0] o_present,
  output logic [7:0] o_probes
);
  logic [3:0] junk = 4'h5;
  logic [7:0] probes = 8'h00;

  // Unpowered detector gives no steady answer
  always @(posedge i_clock) begin
    junk <= ~junk;
    probes <= i_clear ? 8'h00 : probes + {7'h00, i_strobe[3]};
  end
  assign o_present = (i_attached & i_det_en) | (junk & ~i_det_en);
  assign o_probes = probes;
endmodule

`default_nettype wire

// *** bench/rlc_control_assertions.sv ***
// Assertions on rlc_control ports.
// Assumes one clock, reset synchronous active high.
`timescale 1ns/10ps
`default_nettype none

module rlc_control_assertions (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire logic i_detect_request,
  input wire logic i_swing_select,
  input wire logic i_power_save_in,
  input wire logic i_in_boost_msb,
  input wire logic o_swing_large,
  input wire logic o_standby,
  input wire logic [1:0] o_in_boost,
  input wire logic [3:0] o_detect_request_en,
  input wire logic [3:0] o_detect_strobe,
  input wire logic [3:0] o_drive_en,
  input wire logic [3:0] o_idle_det_en,
  input wire logic [3:0] o_lane_out_on
);
  logic [2:0] up;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  // Pins lag by the synchroniser, so wait out reset
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      up <= 3'h0;
    end else if (up != 3'h7) begin
      up <= up + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  sequence s_req_rise;
    up == 3'h7 && i_enable && $past(i_enable, 3) && $rose(i_detect_request) ##1 i_enable [*5];
  endsequence
  sequence s_en_off;
    up == 3'h7 && !$past(i_enable, 4) && !$past(i_enable, 5);
  endsequence
  sequence s_ps_on;
    up == 3'h7 && $past(i_power_save_in, 3) && $past(i_power_save_in, 4);
  endsequence

  ////////////////////////////////////////////////////////////////
  a_boost_decode: assert property (up == 3'h7 && $past(i_in_boost_msb, 3) &&
    $past(i_in_boost_msb, 4) |-> o_in_boost == 2'h2) else $error("boost wrong");
  a_swing_small: assert property (up == 3'h7 && $past(i_swing_select, 3) &&
    $past(i_swing_select, 4) |-> !o_swing_large) else $error("swing wrong");
  a_req_start: assert property (s_req_rise |-> ##[0:3] (o_detect_request_en[0] && o_standby))
    else $error("no detection start");
  a_standby_dark: assert property (o_standby |-> o_drive_en == 4'h0)
    else $error("driver on in standby");
  a_strobe_busy: assert property (o_detect_strobe != 4'h0 |-> o_standby)
    else $error("attempt outside detection");
  a_strobe_single: assert property (o_detect_strobe != 4'h0 |=>
    (o_detect_strobe == 4'h0) [*8]) else $error("attempts too close");
  a_gate_subset: assert property (((o_idle_det_en | o_lane_out_on) & ~o_drive_en) == 4'h0)
    else $error("lane gated on without driver");
  a_disable_idle: assert property (s_en_off |-> o_standby && o_detect_request_en == 4'h0)
    else $error("active while disabled");
  a_ps_slaved: assert property (s_ps_on |-> o_detect_request_en[3:1] == 3'h0 &&
    (o_drive_en == 4'h0 || o_drive_en == 4'hF)) else $error("lanes not slaved");
endmodule

bind rlc_control rlc_control_assertions u_rlc_chk (.i_clock, .i_sys_rst, .i_enable,
  .i_detect_request, .i_swing_select, .i_power_save_in, .i_in_boost_msb,
  .o_swing_large, .o_standby, .o_in_boost, .o_detect_request_en, .o_detect_strobe,
  .o_drive_en, .o_idle_det_en, .o_lane_out_on);

`default_nettype wire

// *** bench/tb.sv ***
// Testbench for rlc_control: pins, lane partner, AHB-Lite access.
// Assumes rlc_params.svh on the include path; 125 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "rlc_params.svh"

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h, expected %h", $time, g, e); end end

module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0, req = 1'b0, sw = 1'b0, ps = 1'b0, clr = 1'b0, hw = 1'b0;
  logic [1:0] bst = 2'h0, dmp = 2'h0, htr = 2'h0, ib, od;
  logic [3:0] above = 4'h0, att = 4'h0, pres, det, stb, drv, idl, lon;
  logic [31:0] ha = 32'h0, hwd = 32'h0, rd, hrd;
  logic [7:0] probes;
  logic rdy, swl, stby, resp;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;

  always #4 clk = ~clk;

  rlc_control dut (
    .i_clock(clk), .i_sys_rst(rst), .i_enable(en), .i_detect_request(req),
    .i_swing_select(sw), .i_power_save_in(ps), .i_in_boost_msb(bst[1]),
    .i_in_boost_lsb(bst[0]), .i_out_deemph_msb(dmp[1]), .i_out_deemph_lsb(dmp[0]),
    .i_rx_present(pres), .i_idle_above(above), .i_hsel(1'b1), .i_haddr(ha),
    .i_htrans(htr), .i_hwrite(hw), .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(rdy),
    .o_hrdata(hrd), .o_hreadyout(rdy), .o_hresp(resp), .o_in_boost(ib),
    .o_out_deemph(od), .o_swing_large(swl), .o_standby(stby), .o_detect_request_en(det),
    .o_detect_strobe(stb), .o_drive_en(drv), .o_idle_det_en(idl), .o_lane_out_on(lon)
  );
  rlc_partner lp (.i_clock(clk), .i_clear(clr), .i_attached(att), .i_det_en(det),
    .i_strobe(stb), .o_present(pres), .o_probes(probes));

  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Waits on hready; only the cycle ceiling ends a hang
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    ha <= {24'h0, a};
    hw <= w;
    htr <= 2'h2;
    do @(posedge clk); while (rdy !== 1'b1);
    htr <= 2'h0;
    hwd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrd;
  endtask

  task automatic wait_run();
    for (int i = 0; i < 3000 && stby !== 1'b0; i++) tick(1);
    tick(2);
  endtask

  function automatic logic [1:0] lvl(input logic [1:0] c);
    lvl = c[1] ? `RLC_EQ_6DB : (c[0] ? `RLC_EQ_3P5DB : `RLC_EQ_NONE);
  endfunction

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    tick(4);
    rst <= 1'b0;
    tick(8);
    `CHK(stby, 1'b1)
    ahb(1'b0, `RLC_ADDR_SETTING, 32'h0);
    `CHK(rd[0], 1'b0)
    ahb(1'b0, 8'h0C, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(resp, 1'b0)
    for (int c = 0; c < 4; c++) begin
      bst <= 2'(c);
      dmp <= 2'(3 - c);
      sw <= c[0];
      tick(6);
      `CHK(ib, lvl(2'(c)))
      `CHK(od, lvl(2'(3 - c)))
      `CHK(swl, ~c[0])
    end
    att <= 4'h3;
    en <= 1'b1;
    tick(8);
    `CHK(det, 4'hF)
    `CHK(drv, 4'h0)
    wait_run();
    `CHK(drv, 4'h3)
    `CHK(idl, 4'h3)
    `CHK(probes, 8'h04)
    ahb(1'b0, `RLC_ADDR_STATUS, 32'h0);
    `CHK(rd[15:0], 16'hF023)
    above <= 4'h5;
    tick(6);
    `CHK(lon, 4'h1)
    att <= 4'h0;
    clr <= 1'b1;
    req <= 1'b1;
    tick(1);
    clr <= 1'b0;
    tick(900);
    `CHK(stby, 1'b1)
    `CHK(probes, 8'h07)
    ahb(1'b0, `RLC_ADDR_STATUS, 32'h0);
    `CHK(rd[15:0], 16'h0010)
    att <= 4'hF;
    wait_run();
    `CHK(drv, 4'hF)
    ps <= 1'b1;
    att <= 4'h1;
    req <= 1'b0;
    tick(4);
    req <= 1'b1;
    tick(8);
    `CHK(det, 4'h1)
    wait_run();
    `CHK(drv, 4'hF)
    `CHK(idl, 4'h1)
    `CHK(lon, 4'hF)
    above <= 4'hE;
    ahb(1'b0, `RLC_ADDR_STATUS, 32'h0);
    `CHK(rd[6], 1'b1)
    tick(6);
    `CHK(lon, 4'h0)
    ps <= 1'b0;
    tick(6);
    ahb(1'b1, `RLC_ADDR_CTRL, 32'h1);
    tick(4);
    `CHK(stby, 1'b1)
    wait_run();
    `CHK(drv, 4'h1)
    en <= 1'b0;
    tick(8);
    `CHK(drv, 4'h0)
    req <= 1'b0;
    tick(4);
    req <= 1'b1;
    tick(8);
    `CHK(det, 4'h0)
    // Controller toggles enable back on: detection restarts
    en <= 1'b1;
    tick(8);
    `CHK(det, 4'hF)
    // Reset during detection with enable high, as at power-up
    rst <= 1'b1;
    tick(4);
    rst <= 1'b0;
    tick(2);
    `CHK(det, 4'h0)
    `CHK(stby, 1'b1)
    tick(6);
    `CHK(det, 4'hF)
    `CHK(stby, 1'b1)
    give_verdict();
  end
endmodule

`default_nettype wire
